// File: hdl/subtract_with_borrow_pkg.sv
// package: opcodes, flag positions and reset values of the subtract unit
package borrow_pkg;

	// ------------------------------------------------------------
	// opcode encodings
	// ------------------------------------------------------------
	localparam logic [4:0] OPC_REG_HI   = 5'h13;   // 1001_1rrr
	localparam logic [7:0] OPC_DIRECT   = 8'h95;   // 1001_0101
	localparam logic [7:0] OPC_INDIRECT = 8'h96;   // 1001_011i, i dropped
	localparam logic [7:0] OPC_IMM      = 8'h94;   // 1001_0100

	// ------------------------------------------------------------
	// status word layout and reset values
	// ------------------------------------------------------------
	localparam int BORROW_BIT = 7;
	localparam int AUX_BIT    = 6;
	localparam int RANGE_BIT  = 2;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [7:0] DADDR_RST = 8'h00;
	localparam int NIB_MSB    = 3;
	localparam int SIGN_LOW   = 6;

	// ------------------------------------------------------------
	// operand source of the current instruction
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_BANK,
		SRC_DIRECT,
		SRC_INDIRECT,
		SRC_IMM
	} src_mode_t;

endpackage

// File: hdl/subtract_borrow_alu.sv
// subtract-with-borrow datapath slice: accumulator and status update
// Notes on behaviour
// - accumulator takes acc minus source minus borrow
// - borrow flag set on bit seven borrow
// - auxiliary carry set on bit three borrow
// - range flag is bit six xor seven borrow
// - source from bank, direct, indirect or immediate
// - register form: one byte, low bits pick register
// - direct form: two bytes, second byte addresses
`timescale 1ns/1ps
module subtract_borrow_alu
(
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rst_b,
	// decoder side
	input  wire logic              i_exec,
	input  wire logic [7:0]        i_opcode,
	input  wire logic [7:0]        i_second_byte,
	// operand fetch side
	input  wire logic [7:0]        i_bank_regs [8],
	input  wire logic [7:0]        i_direct_data,
	input  wire logic [7:0]        i_indirect_data,
	// software writes of the status word
	input  wire logic              i_psw_we,
	input  wire logic [7:0]        i_psw_wdata,
	// results
	output logic [7:0]             o_acc,
	output logic [7:0]             o_psw,
	output logic                   o_done,
	output logic [7:0]             o_direct_addr,
	output borrow_pkg::src_mode_t  o_src_mode
);
	import borrow_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the three flags must sit on distinct bits of the status word
	if (BORROW_BIT == AUX_BIT || BORROW_BIT == RANGE_BIT
		|| AUX_BIT == RANGE_BIT || BORROW_BIT > 7 || AUX_BIT > 7
		|| RANGE_BIT > 7)
	begin : g_flag_clash
		$error("status flag positions clash or leave the word");
	end

	// borrow taps are sized for the nibble and the sign bit below
	if (NIB_MSB != 3 || SIGN_LOW != 6)
	begin : g_tap_size
		$error("borrow tap positions do not fit the tap widths");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] psw;
		logic       done;
		logic [7:0] daddr;
		src_mode_t  mode;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic       hit;
	src_mode_t  mode;
	logic [7:0] src;
	logic [4:0] lo_diff;
	logic [7:0] lo7_diff;
	logic [8:0] full_diff;

	// ------------------------------------------------------------
	// decode and operand select
	// ------------------------------------------------------------
	always_comb
	begin
		hit  = 1'b1;
		mode = SRC_BANK;
		src  = i_bank_regs[i_opcode[2:0]];
		if (i_opcode[7:3] == OPC_REG_HI)
			mode = SRC_BANK;
		else if (i_opcode == OPC_DIRECT)
		begin
			mode = SRC_DIRECT;
			src  = i_direct_data;
		end
		else if ({i_opcode[7:1], 1'b0} == OPC_INDIRECT)
		begin
			mode = SRC_INDIRECT;
			src  = i_indirect_data;
		end
		else if (i_opcode == OPC_IMM)
		begin
			mode = SRC_IMM;
			src  = i_second_byte;
		end
		else
			hit = 1'b0;
	end

	// borrow chain pieces at bits three, six and seven
	assign lo_diff   = {1'b0, o_acc[NIB_MSB:0]}
		- {1'b0, src[NIB_MSB:0]} - {4'h0, o_psw[BORROW_BIT]};
	assign lo7_diff  = {1'b0, o_acc[SIGN_LOW:0]}
		- {1'b0, src[SIGN_LOW:0]} - {7'h00, o_psw[BORROW_BIT]};
	assign full_diff = {1'b0, o_acc} - {1'b0, src}
		- {8'h00, o_psw[BORROW_BIT]};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (i_psw_we)
			st_d.psw = i_psw_wdata;
		// a status write in the same cycle loses to the subtract
		if (i_exec && hit)
		begin
			st_d.acc  = full_diff[7:0];
			st_d.psw  = o_psw;
			st_d.psw[BORROW_BIT] = full_diff[8];
			st_d.psw[AUX_BIT]    = lo_diff[4];
			st_d.psw[RANGE_BIT]  = full_diff[8] ^ lo7_diff[7];
			st_d.done  = 1'b1;
			st_d.mode  = mode;
			st_d.daddr = (mode == SRC_DIRECT) ? i_second_byte
				: st_q.daddr;
		end
	end

	// register the state
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			st_q <= '{acc: ACC_RST, psw: PSW_RST, done: 1'b0,
				daddr: DADDR_RST, mode: SRC_BANK};
		else
			st_q <= st_d;
	end

	assign o_acc         = st_q.acc;
	assign o_psw         = st_q.psw;
	assign o_done        = st_q.done;
	assign o_direct_addr = st_q.daddr;
	assign o_src_mode    = st_q.mode;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// arithmetic result and flags
	chk_acc_result: assert property (
		i_exec && hit |=> o_acc == $past(o_acc) - $past(src)
			- {7'h00, $past(o_psw[BORROW_BIT])})
		else $error("accumulator difference wrong");
	chk_borrow_flag: assert property (
		i_exec && hit |=> o_psw[BORROW_BIT] ==
			({1'b0, $past(src)} + {8'h00, $past(o_psw[BORROW_BIT])}
			> {1'b0, $past(o_acc)}))
		else $error("borrow flag wrong");
	chk_aux_flag: assert property (
		i_exec && hit |=> o_psw[AUX_BIT] ==
			({1'b0, $past(src[3:0])} + {4'h0, $past(o_psw[BORROW_BIT])}
			> {1'b0, $past(o_acc[3:0])}))
		else $error("aux carry flag wrong");
	chk_range_flag: assert property (
		i_exec && hit |=> o_psw[RANGE_BIT] ==
			(($past(o_acc[7]) != $past(src[7]))
			&& (o_acc[7] != $past(o_acc[7]))))
		else $error("range flag wrong");

	// operand routing per addressing form
	chk_bank_source: assert property (
		i_exec && i_opcode[7:3] == OPC_REG_HI |=> o_src_mode == SRC_BANK
			&& o_acc == $past(o_acc)
			- $past(i_bank_regs[i_opcode[2:0]])
			- {7'h00, $past(o_psw[BORROW_BIT])})
		else $error("bank register source not used");
	chk_direct_source: assert property (
		i_exec && i_opcode == OPC_DIRECT |=> o_acc == $past(o_acc)
			- $past(i_direct_data) - {7'h00, $past(o_psw[BORROW_BIT])})
		else $error("direct source not used");
	chk_indirect_source: assert property (
		i_exec && i_opcode[7:1] == OPC_INDIRECT[7:1] |=>
			o_src_mode == SRC_INDIRECT && o_acc == $past(o_acc)
			- $past(i_indirect_data) - {7'h00, $past(o_psw[BORROW_BIT])})
		else $error("indirect source not used");
	chk_mode_select: assert property (
		i_exec && i_opcode == OPC_IMM |=> o_src_mode == SRC_IMM
			&& o_acc == $past(o_acc) - $past(i_second_byte)
			- {7'h00, $past(o_psw[BORROW_BIT])})
		else $error("immediate source not used");

	// sequencing, address capture and the rest of the status word
	chk_done_idle: assert property (
		!i_exec |=> !o_done)
		else $error("done without an instruction");
	// unknown opcodes change nothing but a status write and give no done
	chk_refused_hold: assert property (
		i_exec && i_opcode[7:3] != OPC_REG_HI
			&& i_opcode[7:2] != OPC_IMM[7:2] && !i_psw_we
			|=> o_acc == $past(o_acc) && o_psw == $past(o_psw) && !o_done)
		else $error("refused opcode changed state");
	chk_one_cycle: assert property (
		i_exec && i_opcode[7:3] == OPC_REG_HI |=> o_done
			##1 (!o_done || $past(i_exec)))
		else $error("register form not single cycle");
	chk_direct_addr: assert property (
		i_exec && i_opcode == OPC_DIRECT |=>
			o_direct_addr == $past(i_second_byte)
			&& o_src_mode == SRC_DIRECT)
		else $error("direct address not captured");
	chk_psw_kept: assert property (
		i_exec && hit |=>
			{o_psw[5:3], o_psw[1:0]} ==
			{$past(o_psw[5:3]), $past(o_psw[1:0])})
		else $error("unrelated status bits changed");

	// main scenarios
	cov_bank: cover property (i_exec && mode == SRC_BANK && hit);
	cov_borrow_in: cover property (i_exec && hit && o_psw[BORROW_BIT]);
	cov_range: cover property (i_exec && hit ##1 o_psw[RANGE_BIT]);
	cov_indirect: cover property (i_exec && mode == SRC_INDIRECT && hit);
	cov_direct: cover property (i_exec && mode == SRC_DIRECT && hit);

endmodule // subtract_borrow_alu

// File: sim/op_fetch_model.sv
// operand fetch stand-in: data store read by address or pointer
`timescale 1ns/1ps
module op_fetch_model
(
	// addresses from the decoder
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_ptr,
	// fetched bytes, valid in the execute cycle
	output logic      [7:0] o_direct_data,
	output logic      [7:0] o_indirect_data
);
	// store contents follow the address so the bench can predict them
	assign o_direct_data   = i_addr ^ 8'h5A;
	assign o_indirect_data = i_ptr + 8'h33;
endmodule // op_fetch_model

// File: sim/subtract_borrow_alu_tb_top.sv
// self-checking bench of the subtract-with-borrow slice
`timescale 1ns/1ps
module subtract_borrow_alu_tb_top;
	import borrow_pkg::*;
	logic        clk = 0, rst_b = 0, exec = 0, we = 0, done, ed = 0, ok;
	logic [7:0]  op = 0, sb = 0, wd = 0, ea = 0, ep = 0, eda = 0;
	logic [7:0]  acc, psw, oda, dd, id, s, bank [8];
	src_mode_t   md, m, em = SRC_BANK;
	logic [31:0] r;
	int          seed = 10, miscompares = 0, num_checks = 0;

	subtract_borrow_alu dut_u (.i_mclk(clk), .i_rst_b(rst_b),
		.i_exec(exec), .i_opcode(op), .i_second_byte(sb),
		.i_bank_regs(bank), .i_direct_data(dd), .i_indirect_data(id),
		.i_psw_we(we), .i_psw_wdata(wd), .o_acc(acc), .o_psw(psw),
		.o_done(done), .o_direct_addr(oda), .o_src_mode(md));
	op_fetch_model fm_u (.i_addr(sb), .i_ptr(bank[{2'b00, op[0]}]),
		.o_direct_data(dd), .o_indirect_data(id));

	// expected {acc, status word}: a bit position borrows when the
	// subtrahend plus borrow in exceeds the minuend up to that bit
	function automatic logic [15:0] sub(input logic [7:0] a, b, p);
		logic c;
		logic b7;
		logic b6;
		c  = p[BORROW_BIT];
		b7 = ({1'b0, b} + 9'(c)) > {1'b0, a};
		b6 = ({1'b0, b[6:0]} + 8'(c)) > {1'b0, a[6:0]};
		p[BORROW_BIT] = b7;
		p[AUX_BIT] = ({1'b0, b[3:0]} + 5'(c)) > {1'b0, a[3:0]};
		p[RANGE_BIT] = b7 ^ b6;
		return {8'(a - b - 8'(c)), p};
	endfunction

	task automatic cmp(input logic [7:0] g, e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic final_report;
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// clock and watchdog
	initial
		forever #5 clk = ~clk;
	initial
	begin
		#20000;
		miscompares++;
		final_report;
	end

	// random instructions, walk example first, reset in mid-run
	initial
	begin
		foreach (bank[k]) bank[k] = 8'h00;
		repeat (2) @(posedge clk);
		#1 rst_b = 1;
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk);
			#1;
			cmp(acc, ea);
			cmp(psw, ep);
			cmp({7'h00, done}, {7'h00, ed});
			cmp(oda, eda);
			cmp({6'h00, md}, {6'h00, em});
			r = $random(seed);
			op = i == 0 ? OPC_IMM : i == 1 ? 8'h9A :
				r[3] ? r[15:8] : {4'h9, r[11:8]}; // nibble apart from exec
			sb = i == 0 ? 8'h37 : r[23:16];
			foreach (bank[k]) bank[k] = 8'($random(seed));
			if (i == 1)
				bank[2] = 8'h54;
			exec = r[4] | (i < 2);
			we = r[5] & r[6] & (i > 1);
			wd = r[31:24];
			rst_b = (i != 200);
			#1;
			ok = exec;
			ed = 0;
			casez (op)
				8'b1001_1???: s = bank[op[2:0]];
				OPC_DIRECT:   s = dd;
				8'b1001_011?: s = id;
				OPC_IMM:      s = sb;
				default:      ok = 0;
			endcase
			m = op[3] ? SRC_BANK : op[1] ? SRC_INDIRECT :
				op[0] ? SRC_DIRECT : SRC_IMM;
			if (ok)
			begin
				{ea, ep} = sub(ea, s, ep);
				ed = 1;
				em = m;
				if (op == OPC_DIRECT)
					eda = sb;
			end
			else if (we)
				ep = wd;
			if (!rst_b)
			begin
				{ea, ep, ed, eda} = {ACC_RST, PSW_RST, 1'b0, DADDR_RST};
				em = SRC_BANK;
			end
		end
		final_report;
	end
endmodule // subtract_borrow_alu_tb_top
